// ---- rtl/spx_pkg.sv ----
// Notes on behaviour
// R1: load seven M codes onto outputs, then raise the M strobe
// R2: without done handshake, hold M strobe for hold time, then continue
// R3: hold time should cover one scan cycle of the external controller
// R4: external controller executes the presented M codes on seeing the strobe
// R5: output type 0 analog, 1 two-digit BCD, 2 eight-digit BCD
// R6: BCD modes run open loop only, started and stopped by direction codes
// R7: in BCD mode a new speed loads the speed code and raises speed strobe
// R8: speed transfer starts the block and completes only on aux done
// R9: two-digit mode maps speed ranges to codes by fixed table
// R10: two-digit mode clamps speeds above 9999 to the 9999 code
// R11: eight-digit mode sends speed as packed BCD in thousandths rpm
// R12: analog command follows speed; unipolar when both polarities match
// R13: closed loop via orientation only in analog, encoder, nonzero count
// R14: external controller writes override command and raises override flag
// R15: while override flag high, output follows the override command input
// R16: external controller drops override flag to hand control back
// R17: up to four gears requested with M codes 41 to 44; the code handles three gears, codes 41 to 43
// R18: external controller drops aux done on a strobe, raises it when done
// R19: aux done high for the hold time ends all strobes
// R20: M codes stay stable while the M strobe is high
`default_nettype none
package spx_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] SPX_CFG_OFS    = 8'h00;
  localparam logic [7:0] SPX_HOLD_OFS   = 8'h04;
  localparam logic [7:0] SPX_PULSE_OFS  = 8'h08;
  localparam logic [7:0] SPX_MLO_OFS    = 8'h0c;
  localparam logic [7:0] SPX_MHI_OFS    = 8'h10;
  localparam logic [7:0] SPX_CMD_OFS    = 8'h14;
  localparam logic [7:0] SPX_SPEED_OFS  = 8'h18;
  localparam logic [7:0] SPX_DIR_OFS    = 8'h1c;
  localparam logic [7:0] SPX_STAT_OFS   = 8'h20;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int         SPX_CFG_CWPOL  = 2;
  localparam int         SPX_CFG_CCWPOL = 3;
  localparam int         SPX_CFG_ENC    = 4;
  localparam int         SPX_CMD_MGO    = 0;
  localparam int         SPX_CMD_MACK   = 1;
  localparam int         SPX_CMD_ORIENT = 4;
  localparam logic [1:0] SPX_TYPE_ANA   = 2'h0;
  localparam logic [1:0] SPX_TYPE_BCD2  = 2'h1;
  localparam logic [1:0] SPX_TYPE_BCD8  = 2'h2;
  localparam logic [1:0] SPX_DIR_STOP   = 2'h0;
  localparam logic [1:0] SPX_DIR_CW     = 2'h1;
  localparam logic [1:0] SPX_DIR_CCW    = 2'h2;
  localparam logic [31:0] SPX_HOLD_RST  = 32'h0000_00fa;
  localparam logic [7:0] SPX_GEAR_BASE  = 8'h41;
  localparam logic [7:0] SPX_CODE_MAX   = 8'h99;
  localparam logic [15:0] SPX_CMD_MAX   = 16'h7fff;
  localparam int         SPX_LUT_N      = 70;
  // ****************************************
  // two-digit table: {lowest speed in BCD, code}
  // ****************************************
  localparam logic [23:0] SPX_LUT [SPX_LUT_N] = '{
    24'h0000_00, 24'h0001_20, 24'h0002_26, 24'h0003_29, 24'h0004_32,
    24'h0005_34, 24'h0006_35, 24'h0007_36, 24'h0008_38, 24'h0009_39,
    24'h0010_40, 24'h0012_41, 24'h0013_42, 24'h0014_43, 24'h0016_44,
    24'h0018_45, 24'h0020_46, 24'h0023_47, 24'h0025_48, 24'h0028_49,
    24'h0032_50, 24'h0036_51, 24'h0040_52, 24'h0045_53, 24'h0050_54,
    24'h0056_55, 24'h0063_56, 24'h0071_57, 24'h0080_58, 24'h0090_59,
    24'h0100_60, 24'h0112_61, 24'h0125_62, 24'h0140_63, 24'h0160_64,
    24'h0180_65, 24'h0200_66, 24'h0224_67, 24'h0250_68, 24'h0280_69,
    24'h0315_70, 24'h0355_71, 24'h0400_72, 24'h0450_73, 24'h0500_74,
    24'h0560_75, 24'h0630_76, 24'h0710_77, 24'h0800_78, 24'h0900_79,
    24'h1000_80, 24'h1120_81, 24'h1250_82, 24'h1400_83, 24'h1600_84,
    24'h1800_85, 24'h2000_86, 24'h2240_87, 24'h2500_88, 24'h2800_89,
    24'h3150_90, 24'h3550_91, 24'h4000_92, 24'h4500_93, 24'h5000_94,
    24'h5600_95, 24'h6300_96, 24'h7100_97, 24'h8000_98, 24'h9000_99};
  // ****************************************
  // carriers and states
  // ****************************************
  typedef logic [6:0][7:0] spx_mcodes_t;
  typedef struct packed {
    logic m;
    logic s;
  } spx_strobe_t;
  typedef enum logic [4:0] {
    SPX_IDLE  = 5'b00001,
    SPX_HOLD  = 5'b00010,
    SPX_WLOW  = 5'b00100,
    SPX_WDONE = 5'b01000,
    SPX_GAP   = 5'b10000
  } spx_state_t;
endpackage : spx_pkg
`default_nettype wire

// ---- rtl/spx_speed_lut.sv ----
`default_nettype none
module spx_speed_lut (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [19:0] rpm_bcd_i,
  output logic      [7:0]  code_o
);
  import spx_pkg::*;
  // ****************************************
  // range search
  // ****************************************
  // above 9999 the top digit is set; search with 9999 instead
  wire        over_w = (rpm_bcd_i[19:16] != 4'h0); // R10
  wire [15:0] key_w  = over_w ? 16'h9999 : rpm_bcd_i[15:0];
  logic [7:0] nxt_code;
  // packed BCD keeps numeric order, so plain compares work
  always_comb begin
    nxt_code = 8'h00;
    for (int i = 0; i < SPX_LUT_N; i++) begin
      if (key_w >= SPX_LUT[i][23:8]) begin
        nxt_code = SPX_LUT[i][7:0]; // R9
      end
    end
  end
  // registered read data, one cycle behind the input
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) code_o <= 8'h00;
    else         code_o <= nxt_code;
  end
  lut_clamp_a: assert property ( // R10
    @(posedge clk_i) disable iff (!rstn_i)
    over_w |=> code_o == SPX_CODE_MAX)
    else $error("speed above 9999 not clamped");
  lut_range_a: assert property ( // R9
    @(posedge clk_i) disable iff (!rstn_i)
    (rpm_bcd_i >= 20'h01000 && rpm_bcd_i <= 20'h01119) |=> code_o == 8'h80)
    else $error("range 1000-1119 gave wrong code");
endmodule : spx_speed_lut
`default_nettype wire

// ---- rtl/spx_aux_port.sv ----
// Register access over APB and the register offsets were left to the implementer.
`default_nettype none
module spx_aux_port (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // link to external controller
  output spx_pkg::spx_mcodes_t   m_codes_o,
  output spx_pkg::spx_strobe_t   strobe_o,
  output logic      [31:0]       speed_code_o,
  input  wire logic              aux_done_i,
  input  wire logic [15:0]       override_cmd_i,
  input  wire logic              override_flag_i,
  // spindle drive side
  output logic      [15:0]       spindle_cmd_o,
  output logic      [1:0]        spindle_dir_o,
  output logic                   closed_loop_o
);
  import spx_pkg::*;
  // ****************************************
  // apb decode
  // ****************************************
  wire setup_w = psel_i & ~penable_i;
  wire wr_w    = psel_i & penable_i & pwrite_i;
  wire hit_cfg   = (paddr_i == SPX_CFG_OFS);
  wire hit_hold  = (paddr_i == SPX_HOLD_OFS);
  wire hit_pulse = (paddr_i == SPX_PULSE_OFS);
  wire hit_mlo   = (paddr_i == SPX_MLO_OFS);
  wire hit_mhi   = (paddr_i == SPX_MHI_OFS);
  wire hit_cmd   = (paddr_i == SPX_CMD_OFS);
  wire hit_speed = (paddr_i == SPX_SPEED_OFS);
  wire hit_dir   = (paddr_i == SPX_DIR_OFS);
  wire hit_stat  = (paddr_i == SPX_STAT_OFS);
  wire mapped_w  = hit_cfg | hit_hold | hit_pulse | hit_mlo | hit_mhi |
                   hit_cmd | hit_speed | hit_dir | hit_stat;
  // zero wait states: read data is captured in the setup cycle
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped_w;
  // ****************************************
  // configuration registers
  // ****************************************
  logic [4:0]  cfg_ff;
  logic [31:0] hold_ff;
  logic [15:0] pulse_ff;
  logic [55:0] mreq_ff;
  logic [31:0] speed_ff;
  logic [1:0]  dir_ff;
  wire  [1:0]  type_w = cfg_ff[1:0];
  wire         bcd_w  = (type_w == SPX_TYPE_BCD2) ||
                        (type_w == SPX_TYPE_BCD8);
  // plain storage of software settings
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_ff   <= 5'h00;
      hold_ff  <= SPX_HOLD_RST;
      pulse_ff <= 16'h0000;
      mreq_ff  <= 56'h0;
      speed_ff <= 32'h0000_0000;
      dir_ff   <= SPX_DIR_STOP;
    end else if (wr_w) begin
      if (hit_cfg)   cfg_ff         <= pwdata_i[4:0]; // R5
      if (hit_hold)  hold_ff        <= pwdata_i;
      if (hit_pulse) pulse_ff       <= pwdata_i[15:0];
      if (hit_mlo)   mreq_ff[31:0]  <= pwdata_i;
      if (hit_mhi)   mreq_ff[55:32] <= pwdata_i[23:0];
      if (hit_speed) speed_ff       <= pwdata_i;
      if (hit_dir)   dir_ff         <= pwdata_i[1:0]; // R6
    end
  end
  // ****************************************
  // request capture
  // ****************************************
  wire  cmd_wr_w  = wr_w & hit_cmd;
  wire  mgo_w     = cmd_wr_w & pwdata_i[SPX_CMD_MGO];
  wire  [1:0] gear_w = pwdata_i[3:2];
  wire  gear_go_w = cmd_wr_w & (gear_w != 2'h0);
  wire  spd_wr_w  = wr_w & hit_speed & bcd_w;
  logic m_pend_ff, m_ack_ff, gear_ff, s_dly_ff, s_pend_ff;
  logic [7:0] gear_code_ff;
  logic       launch_w;
  // the table output lags the speed by a cycle, so the request waits too
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      m_pend_ff    <= 1'b0;
      m_ack_ff     <= 1'b0;
      gear_ff      <= 1'b0;
      gear_code_ff <= 8'h00;
      s_dly_ff     <= 1'b0;
      s_pend_ff    <= 1'b0;
    end else begin
      // a new request wins over the clear of the launch
      if (mgo_w | gear_go_w) begin
        m_pend_ff <= 1'b1;
        m_ack_ff  <= pwdata_i[SPX_CMD_MACK] | gear_go_w;
        gear_ff   <= gear_go_w;
      end else if (launch_w) begin
        m_pend_ff <= 1'b0;
      end
      if (gear_go_w) begin
        gear_code_ff <= SPX_GEAR_BASE + {6'h00, gear_w} - 8'h01; // R17
      end
      s_dly_ff <= spd_wr_w; // R7
      if (s_dly_ff)      s_pend_ff <= 1'b1;
      else if (launch_w) s_pend_ff <= 1'b0;
    end
  end
  // ****************************************
  // strobe sequencer
  // ****************************************
  spx_state_t  state_ff, nxt_state;
  logic [31:0] cnt_ff, nxt_cnt;
  spx_strobe_t nxt_strobe;
  wire [31:0]  cnt_inc = cnt_ff + 32'h1;
  wire         ack_path_w = s_pend_ff | m_ack_ff;
  assign launch_w = (state_ff == SPX_IDLE) & (m_pend_ff | s_pend_ff);
  // one pass per block: strobes on, timed or acknowledged, then a gap
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_strobe = strobe_o;
    case (state_ff)
      SPX_IDLE: begin
        if (launch_w) begin
          nxt_strobe.m = m_pend_ff; // R1
          nxt_strobe.s = s_pend_ff; // R7
          nxt_cnt      = 32'h1;
          nxt_state    = ack_path_w ? SPX_WLOW : SPX_HOLD; // R8
        end
      end
      SPX_HOLD: begin
        if (cnt_ff >= hold_ff) begin
          nxt_strobe = '0; // R2 R20
          nxt_cnt    = 32'h1;
          nxt_state  = SPX_GAP;
        end else begin
          nxt_cnt = cnt_inc;
        end
      end
      SPX_WLOW: begin
        if (!aux_done_i) begin
          nxt_cnt   = 32'h0;
          nxt_state = SPX_WDONE;
        end
      end
      SPX_WDONE: begin
        if (!aux_done_i) begin
          nxt_cnt = 32'h0;
        end else if (cnt_inc >= hold_ff) begin
          nxt_strobe = '0; // R19
          nxt_cnt    = 32'h1;
          nxt_state  = SPX_GAP;
        end else begin
          nxt_cnt = cnt_inc;
        end
      end
      SPX_GAP: begin
        // keeps strobe off for a hold time before the next block
        if (cnt_ff >= hold_ff) nxt_state = SPX_IDLE;
        else                   nxt_cnt   = cnt_inc;
      end
      default: begin
        nxt_state  = SPX_IDLE;
        nxt_strobe = '0;
      end
    endcase
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= SPX_IDLE;
      cnt_ff   <= 32'h0;
      strobe_o <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      strobe_o <= nxt_strobe;
    end
  end
  // ****************************************
  // code outputs
  // ****************************************
  logic [7:0] lut_code;
  spx_speed_lut u_lut (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .rpm_bcd_i (speed_ff[31:12]),
    .code_o    (lut_code)
  );
  wire [31:0] scode_w = (type_w == SPX_TYPE_BCD8) ? speed_ff // R11
                                                  : {24'h0, lut_code};
  wire [55:0] mload_w = gear_ff ? {48'h0, gear_code_ff} : mreq_ff;
  // codes change only at launch, so they hold while the strobe is high
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      m_codes_o    <= '0;
      speed_code_o <= 32'h0;
    end else if (launch_w) begin
      if (m_pend_ff) m_codes_o    <= mload_w; // R1 R20
      if (s_pend_ff) speed_code_o <= scode_w; // R7
    end
  end
  // ****************************************
  // spindle command and loop mode
  // ****************************************
  wire [16:0] rpm_w = 17'(speed_ff[31:28]) * 17'd10000 +
                      17'(speed_ff[27:24]) * 17'd1000 +
                      17'(speed_ff[23:20]) * 17'd100 +
                      17'(speed_ff[19:16]) * 17'd10 +
                      17'(speed_ff[15:12]);
  wire [15:0] mag_w  = (rpm_w > 17'(SPX_CMD_MAX)) ? SPX_CMD_MAX
                                                  : rpm_w[15:0];
  wire        uni_w  = cfg_ff[SPX_CFG_CWPOL] == cfg_ff[SPX_CFG_CCWPOL];
  wire        neg_w  = (dir_ff == SPX_DIR_CCW) & ~uni_w; // R12
  wire [15:0] ana_w  = (dir_ff == SPX_DIR_STOP) ? 16'h0000 :
                       neg_w ? 16'(-mag_w) : mag_w; // R12
  wire [15:0] nxt_cmd = override_flag_i ? override_cmd_i : // R15
                        bcd_w ? 16'h0000 : ana_w;
  wire        cl_ok_w = (type_w == SPX_TYPE_ANA) & cfg_ff[SPX_CFG_ENC] &
                        (pulse_ff != 16'h0000); // R13
  wire        orient_w = cmd_wr_w & pwdata_i[SPX_CMD_ORIENT];
  wire        nxt_cl   = cl_ok_w & (orient_w | (closed_loop_o &
                         ~(wr_w & hit_dir))); // R6 R13
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      spindle_cmd_o <= 16'h0000;
      spindle_dir_o <= SPX_DIR_STOP;
      closed_loop_o <= 1'b0;
    end else begin
      spindle_cmd_o <= nxt_cmd;
      spindle_dir_o <= dir_ff;
      closed_loop_o <= nxt_cl;
    end
  end
  // ****************************************
  // read data
  // ****************************************
  wire [31:0] stat_w = {25'h0, m_pend_ff, strobe_o.s, strobe_o.m,
                        aux_done_i, override_flag_i, closed_loop_o,
                        ~state_ff[0]};
  wire [31:0] rd_w = hit_cfg   ? {27'h0, cfg_ff}   :
                     hit_hold  ? hold_ff           :
                     hit_pulse ? {16'h0, pulse_ff} :
                     hit_mlo   ? mreq_ff[31:0]     :
                     hit_mhi   ? {8'h0, mreq_ff[55:32]} :
                     hit_speed ? speed_ff          :
                     hit_dir   ? {30'h0, dir_ff}   :
                     hit_stat  ? stat_w            : 32'h0;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)      prdata_o <= 32'h0;
    else if (setup_w) prdata_o <= rd_w;
  end
  // ****************************************
  // checks
  // ****************************************
  logic [31:0] len_ff;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)         len_ff <= 32'h0;
    else if (strobe_o.m) len_ff <= len_ff + 32'h1;
    else                 len_ff <= 32'h0;
  end
  // the count is seen one edge after the fall, once its last step landed
  sequence s_m_fall;
    $fell(strobe_o.m) && ($past(state_ff) == SPX_HOLD);
  endsequence
  // done must have stood on the two samples before the strobe fell
  sequence s_s_fall;
    $fell(strobe_o.s) && (hold_ff > 32'h1);
  endsequence
  hold_len_a: assert property ( // R2
    @(posedge clk_i) disable iff (!rstn_i)
    s_m_fall |->
      len_ff == (($past(hold_ff) == 32'h0) ? 32'h1 : $past(hold_ff)))
    else $error("timed M strobe length differs from hold time");
  codes_hold_a: assert property ( // R20
    @(posedge clk_i) disable iff (!rstn_i)
    (strobe_o.m && $past(strobe_o.m)) |-> $stable(m_codes_o))
    else $error("M codes changed under the strobe");
  mload_a: assert property ( // R1
    @(posedge clk_i) disable iff (!rstn_i)
    (launch_w && m_pend_ff && !gear_ff) |=>
    (m_codes_o == $past(mreq_ff) && strobe_o.m))
    else $error("M codes not loaded with strobe");
  ack_end_a: assert property ( // R19
    @(posedge clk_i) disable iff (!rstn_i)
    s_s_fall |-> ($past(aux_done_i) && $past(aux_done_i, 2)))
    else $error("speed strobe dropped without aux done held");
  sdone_a: assert property ( // R8
    @(posedge clk_i) disable iff (!rstn_i)
    (strobe_o.s && !aux_done_i) |=> strobe_o.s)
    else $error("speed strobe ended before aux done");
  bcd8_a: assert property ( // R11
    @(posedge clk_i) disable iff (!rstn_i)
    (launch_w && s_pend_ff && type_w == SPX_TYPE_BCD8) |=>
    speed_code_o == $past(speed_ff))
    else $error("eight-digit speed code wrong");
  open_loop_a: assert property ( // R6 R13
    @(posedge clk_i) disable iff (!rstn_i)
    $rose(closed_loop_o) |-> $past(cl_ok_w))
    else $error("closed loop entered when not allowed");
  override_a: assert property ( // R15
    @(posedge clk_i) disable iff (!rstn_i)
    override_flag_i |=> spindle_cmd_o == $past(override_cmd_i))
    else $error("override command not followed");
  unipolar_a: assert property ( // R12
    @(posedge clk_i) disable iff (!rstn_i)
    (!override_flag_i && !bcd_w && uni_w) |=> !spindle_cmd_o[15])
    else $error("unipolar command went negative");
  bcd_cmd_a: assert property ( // R5
    @(posedge clk_i) disable iff (!rstn_i)
    (!override_flag_i && bcd_w) |=> spindle_cmd_o == 16'h0000)
    else $error("analog command driven in BCD mode");
endmodule : spx_aux_port
`default_nettype wire

// ---- dv/spx_plc_model.sv ----
`default_nettype none
module spx_plc_model (
  input  wire logic                 clk_i,
  input  wire logic                 rstn_i,
  input  wire spx_pkg::spx_strobe_t strobe_i,
  input  wire spx_pkg::spx_mcodes_t m_codes_i,
  input  wire logic [7:0]           work_i,
  output logic                      aux_done_o,
  output spx_pkg::spx_mcodes_t      seen_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import spx_pkg::*;
  // ****************************************
  // one controller scan per strobe
  // ****************************************
  logic       any_ff;
  logic [7:0] cnt_ff;
  wire logic  rise = (strobe_i.m | strobe_i.s) & !any_ff;
  // done drops on any new strobe and comes back work_i+1 cycles later;
  // it also drops on plain pulses, to prove they ignore it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aux_done_o <= 1'b1;
      any_ff     <= 1'b0;
      cnt_ff     <= 8'h0;
      seen_o     <= '0;
    end else begin
      any_ff <= strobe_i.m | strobe_i.s;
      if (rise) begin
        aux_done_o <= 1'b0;
        cnt_ff     <= work_i;
        if (strobe_i.m) seen_o <= m_codes_i;
      end else if (cnt_ff != 8'h0) begin
        cnt_ff <= cnt_ff - 8'h1;
      end else begin
        aux_done_o <= 1'b1;
      end
    end
  end
endmodule : spx_plc_model
`default_nettype wire

// ---- dv/spx_aux_port_tb.sv ----
`default_nettype none
module spx_aux_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spx_pkg::*;
  // ****************************************
  // stimulus and observation
  // ****************************************
  localparam logic [31:0] HOLD = 32'h2;
  logic        clk_i = 1'b0, rstn_i = 1'b0, psel = 1'b0, pen = 1'b0;
  logic        pwr = 1'b0, ov_flag = 1'b0;
  logic [7:0]  paddr = 8'h0, work = 8'h3;
  logic [15:0] ov_cmd = 16'h0, scmd;
  logic [31:0] pwdata = 32'h0, prdata, speed_code, rd, exp_sc;
  logic        pready, perr, err, aux_done, closed;
  logic [1:0]  sdir;
  logic [55:0] codes;
  spx_mcodes_t mcodes, seen;
  spx_strobe_t strobe;
  int          error_cnt = 0;
  int          check_count = 0;
  int          tot, ah, r;
  int          sv[8] = '{0, 1000, 12000, 1000000, 1119999, 1120000,
                         9999000, 12000000};
  logic [7:0]  sc[8] = '{8'h00, 8'h20, 8'h41, 8'h80, 8'h80, 8'h81,
                         8'h99, 8'h99};
  // cycle clock, 250 MHz
  always #2 clk_i = ~clk_i;
  spx_aux_port u_spx_aux_port (
    .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .m_codes_o(mcodes), .strobe_o(strobe), .speed_code_o(speed_code),
    .aux_done_i(aux_done), .override_cmd_i(ov_cmd),
    .override_flag_i(ov_flag), .spindle_cmd_o(scmd),
    .spindle_dir_o(sdir), .closed_loop_o(closed));
  spx_plc_model u_spx_plc_model (
    .clk_i(clk_i), .rstn_i(rstn_i), .strobe_i(strobe),
    .m_codes_i(mcodes), .work_i(work), .aux_done_o(aux_done),
    .seen_o(seen));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] bcd(input int v);
    logic [31:0] b;
    for (int i = 0; i < 8; i++) begin
      b[4*i +: 4] = 4'(v % 10);
      v = v / 10;
    end
    return b;
  endfunction : bcd
  task automatic chk(input logic [63:0] g, e, input string m);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  // request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk(64'(pready), 64'h1, "pready");
    rd  = prdata;
    err = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  // measures one strobe; ah counts done-high cycles after done dropped
  task automatic pulse(input bit s);
    int k;
    bit lo;
    k = 0;
    lo = 0;
    tot = 0;
    ah = 0;
    while ((s ? strobe.s : strobe.m) !== 1'b1 && k++ < 400)
      @(negedge clk_i);
    while ((s ? strobe.s : strobe.m) === 1'b1 && tot < 400) begin
      if (s) chk(64'(speed_code), 64'(exp_sc), "speed code");
      else chk(64'(mcodes), 64'(codes), "m codes");
      tot++;
      lo = lo | (aux_done === 1'b0);
      ah += int'(lo && aux_done === 1'b1);
      @(negedge clk_i);
    end
  endtask : pulse
  // bounded wait lets the drive path take its own latency
  task automatic ana(input int rpm, input logic [1:0] dir,
                     input logic [31:0] cfg, input logic [15:0] e);
    int k;
    apb(1'b1, SPX_CFG_OFS, cfg);
    apb(1'b1, SPX_DIR_OFS, {30'h0, dir});
    apb(1'b1, SPX_SPEED_OFS, bcd(rpm * 1000));
    for (k = 0; k < 20 && scmd !== e; k++) @(negedge clk_i);
    chk(64'(scmd), 64'(e), "spindle command");
    chk(64'(sdir), 64'(dir), "spindle direction");
  endtask : ana
  task automatic cl(input logic [31:0] cfg, p, input logic e);
    int k;
    apb(1'b1, SPX_CFG_OFS, cfg);
    apb(1'b1, SPX_PULSE_OFS, p);
    apb(1'b1, SPX_CMD_OFS, 32'h10);
    for (k = 0; k < 8 && closed !== e; k++) @(negedge clk_i);
    chk(64'(closed), 64'(e), "closed loop");
  endtask : cl
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  // ****************************************
  // tests
  // ****************************************
  initial begin
    r = $urandom(32'h6234);
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    apb(1'b0, SPX_HOLD_OFS, 32'h0);
    chk(64'(rd), 64'(SPX_HOLD_RST), "hold reset");
    apb(1'b0, SPX_STAT_OFS, 32'h0);
    chk(64'(rd), 64'h8, "status idle");
    apb(1'b0, 8'h24, 32'h0);
    chk(64'({err, rd}), 64'h1_0000_0000, "unmapped read");
    apb(1'b1, SPX_HOLD_OFS, HOLD);
    apb(1'b0, SPX_HOLD_OFS, 32'h0);
    chk(64'(rd), 64'(HOLD), "hold readback");
    $display("test registers done");
    // second request lands while the first pulse is busy
    work  <= 8'd20;
    rd    = bcd($urandom_range(0, 999999));
    codes = {rd[23:0], bcd($urandom_range(0, 99999999))};
    apb(1'b1, SPX_MLO_OFS, codes[31:0]);
    apb(1'b1, SPX_MHI_OFS, {8'h0, codes[55:32]});
    apb(1'b1, SPX_CMD_OFS, 32'h1);
    fork
      apb(1'b1, SPX_CMD_OFS, 32'h1);
      begin
        pulse(1'b0);
        chk(64'(tot), 64'(HOLD), "m strobe width");
        pulse(1'b0);
        chk(64'(tot), 64'(HOLD), "queued m strobe");
      end
    join
    chk(64'(seen), 64'(codes), "codes at controller");
    $display("test m transfer done");
    work <= 8'd3;
    // acknowledged M codes, then a gear request that always waits for done
    apb(1'b1, SPX_CMD_OFS, 32'h3);
    pulse(1'b0);
    chk(64'(ah), 64'(HOLD), "m done hold");
    codes = 56'h42;
    apb(1'b1, SPX_CMD_OFS, 32'h8);
    pulse(1'b0);
    chk(64'(seen), 64'(codes), "gear code");
    $display("test ack and gear done");
    apb(1'b1, SPX_CFG_OFS, {30'h0, SPX_TYPE_BCD2});
    foreach (sv[i]) begin
      exp_sc = {24'h0, sc[i]};
      apb(1'b1, SPX_SPEED_OFS, bcd(sv[i]));
      pulse(1'b1);
      chk(64'(ah), 64'(HOLD), "done hold");
    end
    apb(1'b1, SPX_CFG_OFS, {30'h0, SPX_TYPE_BCD8});
    exp_sc = bcd($urandom_range(0, 99999999));
    apb(1'b1, SPX_SPEED_OFS, exp_sc);
    pulse(1'b1);
    chk(64'(ah), 64'(HOLD), "done hold wide");
    $display("test speed transfer done");
    r = $urandom_range(1, 9999);
    ana(r, SPX_DIR_CCW, 32'h4, -16'(r));
    ana(r, SPX_DIR_CCW, 32'hc, 16'(r));
    ana(40000, SPX_DIR_CW, 32'h4, SPX_CMD_MAX);
    ana(r, SPX_DIR_CW, 32'h4, 16'(r));
    // controller takes the command over and changes it once
    repeat (2) begin
      @(posedge clk_i);
      ov_flag <= 1'b1;
      ov_cmd  <= 16'($urandom);
      @(posedge clk_i);
      @(negedge clk_i);
      chk(64'(scmd), 64'(ov_cmd), "override follows");
    end
    @(posedge clk_i);
    ov_flag <= 1'b0;
    ana(r, SPX_DIR_CW, 32'h4, 16'(r));
    ana(r, SPX_DIR_STOP, 32'h4, 16'h0);
    $display("test analog done");
    cl(32'h10, 32'h8, 1'b1);
    cl(32'h10, 32'h0, 1'b0);
    cl(32'h11, 32'h8, 1'b0);
    cl(32'h0, 32'h8, 1'b0);
    ana(r, SPX_DIR_CW, 32'h1, 16'h0);
    $display("test closed loop done");
    summarize();
  end
  // a hang ends the run; all tests take about a microsecond
  initial begin
    #40us;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end
endmodule : spx_aux_port_tb
`default_nettype wire
